/* prs_checker.sv */
// Port assertions for the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module prs_checker (
  input wire logic ref_clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic rst_pin_n, // Pin
  input wire logic [2:0] strap_pins, // Straps in
  input wire prs_pkg::prs_addr_t addr, // Offset
  input wire prs_pkg::prs_data_t wdata, // Data
  input wire logic wr, // Write
  input wire logic rd, // Read
  input wire logic [15:0] rdata, // Read data
  input wire logic core_rst_n, // Core reset
  input wire logic std_regs_rst, // Std pulse
  input wire logic [2:0] strap_latched // Straps kept
);
  import prs_pkg::*;
  logic [5:0] low_run;
  // Saturates so a long hold never wraps
  // Cleared in reset so the power-up hold of the pin is measured too
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      low_run <= 6'h00;
    end else begin
      low_run <= rst_pin_n ? 6'h00 : low_run + {5'h00, ~&low_run};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_glb; wr && addr == 12'h01F && wdata[15] && core_rst_n; endsequence
  property p_pin_long; low_run >= 6'h1E |-> !core_rst_n; endproperty
  a_pin_long: assert property (p_pin_long) else $error("long pin low, core free");
  property p_pin_short; $rose(rst_pin_n) && low_run < 6'h0A && core_rst_n |-> core_rst_n[*4];
  endproperty
  a_pin_short: assert property (p_pin_short) else $error("short pin pulse acted");
  property p_strap_cap; $rose(rst_pin_n) && low_run >= 6'h1E |-> ##[1:6] strap_latched == strap_pins;
  endproperty
  a_strap_cap: assert property (p_strap_cap) else $error("straps not recaptured");
  property p_std_rst; wr && addr == 12'h000 && wdata[15] && core_rst_n |-> ##[1:24] std_regs_rst;
  endproperty
  a_std_rst: assert property (p_std_rst) else $error("no standard reset pulse");
  property p_glb_hold; s_glb |-> ##2 (!core_rst_n)[*8]; endproperty
  a_glb_hold: assert property (p_glb_hold) else $error("core not held in reset");
  property p_glb_done; s_glb |-> ##[10:24] std_regs_rst; endproperty
  a_glb_done: assert property (p_glb_done) else $error("global reset missed registers");
  property p_strap_keep; s_glb |-> ##1 $stable(strap_latched)[*8]; endproperty
  a_strap_keep: assert property (p_strap_keep) else $error("straps moved in reset");
  property p_restart; wr && addr == 12'h01F && wdata == 16'h4000 && core_rst_n |->
    ##2 (!core_rst_n ##0 (!std_regs_rst throughout ##22 1)); endproperty
  a_restart: assert property (p_restart) else $error("restart touched registers");
endmodule
bind prs_top prs_checker u_prs_checker (.ref_clk, .reset_n, .rst_pin_n, .strap_pins, .addr,
  .wdata, .wr, .rd, .rdata, .core_rst_n, .std_regs_rst, .strap_latched);
`default_nettype wire

/* prs_ctl_if.sv */
// Reset request and status between top and action timer
`timescale 1ns/10ps
`default_nettype none
interface prs_ctl_if;
  import prs_pkg::*;
  logic start;
  prs_act_t kind;
  logic busy;
  logic done;
  prs_act_t done_kind;
  modport ctl (output start, output kind, input busy, input done, input done_kind);
  modport tmr (input start, input kind, output busy, output done, output done_kind);
endinterface
`default_nettype wire

/* prs_defines.svh */
// Offsets, field positions, reset values and timing counts for the reset sequencer
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH
`define PRS_CLK_HZ 25000000
`define PRS_PIN_MIN_NS 1000
`define PRS_PIN_MIN_CYC ((`PRS_PIN_MIN_NS * 25 + 999) / 1000)
`define PRS_POWERUP_MS 200
`define PRS_POWERUP_CYC (`PRS_POWERUP_MS * (`PRS_CLK_HZ / 1000))
`define PRS_ACT_CYC 16
`define PRS_OFS_BMC 12'h000
`define PRS_OFS_GEN 12'h01F
`define PRS_OFS_STD_LAST 12'h00F
`define PRS_OFS_EXT 12'h010
`define PRS_OFS_STRAP 12'h06E
`define PRS_OFS_MODE 12'h01D
`define PRS_FIBER_BASE 12'hC00
`define PRS_FIBER_LAST 12'hC1F
`define PRS_BIT_SWRST 15
`define PRS_BIT_GRST 15
`define PRS_BIT_RESTART 14
`define PRS_BMC_RST 16'h1140
`define PRS_GEN_RST 16'h0000
`define PRS_EXT_RST 16'h0000
`define PRS_FIB_RST 16'h0000
`define PRS_MODE_RST 3'h0
`define PRS_MODE_FIB1G 3'h2
`define PRS_MODE_FIB100 3'h3
`endif

/* prs_host.sv */
// Host model: reset pin and register bus master
`timescale 1ns/10ps
`default_nettype none
module prs_host #(parameter int PWR_CYC = 40) (
  input wire logic ref_clk, // Clock
  output logic rst_pin_n, // Reset pin
  output prs_pkg::prs_addr_t addr, // Offset
  output prs_pkg::prs_data_t wdata, // Data
  output logic wr, // Write
  output logic rd, // Read
  input wire logic [15:0] rdata // Read data
);
  import prs_pkg::*;
  initial begin
    rst_pin_n = 1'b0;
    addr = 12'h000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    // Shortened power-up hold; the full span would dominate the run
    repeat (PWR_CYC) @(posedge ref_clk);
    rst_pin_n <= 1'b1;
  end
  task automatic pulse(input int n);
    @(posedge ref_clk);
    rst_pin_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rst_pin_n <= 1'b1;
  endtask
  // Callers pass listed offsets only
  task automatic write(input prs_addr_t a, input prs_data_t d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic read(input prs_addr_t a, output prs_data_t d);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

/* prs_pkg.sv */
// Types shared by the reset sequencer files
package prs_pkg;
  typedef logic [11:0] prs_addr_t;
  typedef logic [15:0] prs_data_t;
  typedef enum logic [1:0] {PRS_IDLE, PRS_STD, PRS_GLOBAL, PRS_RESTART} prs_act_t;
endpackage

/* prs_timer.sv */
// Action timer holding internal circuits in reset for a fixed span
`timescale 1ns/10ps
`default_nettype none
`include "prs_defines.svh"
module prs_timer (
  input wire logic ref_clk, // Clock
  input wire logic reset_n, // Synchronous reset, active low
  prs_ctl_if.tmr ctl // Request and status
);
  import prs_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    prs_act_t kind;
    logic busy;
    logic done;
  } prs_tmr_st_t;
  prs_tmr_st_t st;
  prs_tmr_st_t next_st;
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (ctl.start && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.kind = ctl.kind;
      next_st.cnt = 8'(`PRS_ACT_CYC - 1);
    end else if (st.busy) begin
      if (st.cnt == 8'h00) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 8'h01;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign ctl.busy = st.busy;
  assign ctl.done = st.done;
  assign ctl.done_kind = st.kind;
endmodule
`default_nettype wire

/* prs_top.sv */
// Reset sequencer and register-space decode of the transceiver
`timescale 1ns/10ps
`default_nettype none
`include "prs_defines.svh"
// Notes on behaviour
// - Pin low 1us or more: full reset
// - Hardware reset: defaults and strap recapture
// - Basic control bit 15: standard registers only
// - General control bit 15: every register except the latched straps resets
// - Global reset keeps the latched straps
// - General control bit 14: restart, registers kept
// - Fiber modes map fiber block onto base
module prs_top (
  input wire logic ref_clk, // Clock, 25 MHz
  input wire logic reset_n, // Power-on reset, synchronous, active low
  input wire logic rst_pin_n, // External hardware reset pin, asynchronous
  input wire logic [2:0] strap_pins, // Strap levels, asynchronous
  input wire prs_pkg::prs_addr_t addr, // Register offset
  input wire prs_pkg::prs_data_t wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after rd
  output logic core_rst_n, // Internal circuits reset, active low
  output logic std_regs_rst, // Pulse when a bit 15 write resets standard registers
  output logic [2:0] strap_latched // Latched strap configuration
);
  import prs_pkg::*;
  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] strap_sync0;
    logic [1:0] strap_sync1;
    logic [1:0] strap_sync2;
    logic [7:0] low_cnt;
    logic hw_rst;
    logic strap_take;
    logic [2:0] straps;
    logic [15:0] bmc;
    logic [15:0] gen;
    logic [15:0] ext;
    logic [15:0] fib;
    logic [2:0] mode;
    logic [15:0] rdata;
    logic std_pulse;
  } prs_st_t;
  prs_st_t st;
  prs_st_t next_st;
  prs_ctl_if ctl ();
  prs_timer u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n && !st.hw_rst),
    .ctl(ctl.tmr)
  );

  function automatic logic fiber_mode(input logic [2:0] m);
    return (m == `PRS_MODE_FIB1G) || (m == `PRS_MODE_FIB100);
  endfunction

  // Folds an access onto the fiber block when the base map is aliased
  function automatic logic [11:0] map_addr(input logic [11:0] a, input logic [2:0] m);
    if (fiber_mode(m) && a <= `PRS_OFS_STD_LAST) begin
      return `PRS_FIBER_BASE | a;
    end
    return a;
  endfunction

  logic [11:0] eff_addr;
  logic pin_low;
  assign eff_addr = map_addr(addr, st.mode);
  assign pin_low = !st.pin_sync[1];

  always_comb begin
    next_st = st;
    next_st.pin_sync = {st.pin_sync[0], rst_pin_n};
    next_st.strap_sync0 = {st.strap_sync0[0], strap_pins[0]};
    next_st.strap_sync1 = {st.strap_sync1[0], strap_pins[1]};
    next_st.strap_sync2 = {st.strap_sync2[0], strap_pins[2]};
    next_st.std_pulse = 1'b0;
    next_st.strap_take = 1'b0;
    ctl.start = 1'b0;
    ctl.kind = PRS_IDLE;
    // Short glitches on the pin are ignored; only a qualifying low resets
    if (pin_low) begin
      if (st.low_cnt != 8'(`PRS_PIN_MIN_CYC)) begin
        next_st.low_cnt = st.low_cnt + 8'h01;
      end
    end else begin
      next_st.low_cnt = 8'h00;
    end
    if (pin_low && st.low_cnt == 8'(`PRS_PIN_MIN_CYC - 1)) begin
      next_st.hw_rst = 1'b1;
    end
    if (!pin_low && st.hw_rst) begin
      next_st.hw_rst = 1'b0;
      next_st.strap_take = 1'b1;
    end
    if (st.hw_rst) begin
      next_st.bmc = `PRS_BMC_RST;
      next_st.gen = `PRS_GEN_RST;
      next_st.ext = `PRS_EXT_RST;
      next_st.fib = `PRS_FIB_RST;
      next_st.mode = `PRS_MODE_RST;
    end else begin
      if (wr) begin
        unique case (eff_addr)
          `PRS_OFS_BMC: begin
            next_st.bmc = wdata;
            if (wdata[`PRS_BIT_SWRST]) begin
              ctl.start = 1'b1;
              ctl.kind = PRS_STD;
            end
          end
          `PRS_OFS_GEN: begin
            next_st.gen = wdata;
            if (wdata[`PRS_BIT_GRST]) begin
              ctl.start = 1'b1;
              ctl.kind = PRS_GLOBAL;
            end else if (wdata[`PRS_BIT_RESTART]) begin
              ctl.start = 1'b1;
              ctl.kind = PRS_RESTART;
            end
          end
          `PRS_OFS_EXT: next_st.ext = wdata;
          `PRS_OFS_MODE: next_st.mode = wdata[2:0];
          default: begin
            // Fiber block and reserved offsets
            if (eff_addr >= `PRS_FIBER_BASE && eff_addr <= `PRS_FIBER_LAST) begin
              next_st.fib = wdata;
            end
          end
        endcase
      end
      if (ctl.done) begin
        unique case (ctl.done_kind)
          PRS_STD: begin
            next_st.bmc = `PRS_BMC_RST;
            next_st.std_pulse = 1'b1;
          end
          PRS_GLOBAL: begin
            next_st.bmc = `PRS_BMC_RST;
            next_st.gen = `PRS_GEN_RST;
            next_st.ext = `PRS_EXT_RST;
            next_st.fib = `PRS_FIB_RST;
            next_st.mode = `PRS_MODE_RST;
            next_st.std_pulse = 1'b1;
          end
          PRS_RESTART: next_st.gen[`PRS_BIT_RESTART] = 1'b0;
          PRS_IDLE: next_st.gen = st.gen;
        endcase
      end
    end
    if (st.strap_take) begin
      next_st.straps = {st.strap_sync2[1], st.strap_sync1[1], st.strap_sync0[1]};
    end
    next_st.rdata = 16'h0000;
    if (rd) begin
      unique case (eff_addr)
        `PRS_OFS_BMC: next_st.rdata = st.bmc;
        `PRS_OFS_GEN: next_st.rdata = st.gen;
        `PRS_OFS_EXT: next_st.rdata = st.ext;
        `PRS_OFS_MODE: next_st.rdata = {13'h0000, st.mode};
        `PRS_OFS_STRAP: next_st.rdata = {13'h0000, st.straps};
        default: begin
          if (eff_addr >= `PRS_FIBER_BASE && eff_addr <= `PRS_FIBER_LAST) begin
            next_st.rdata = st.fib;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
      st.pin_sync <= 2'h3;
      st.bmc <= `PRS_BMC_RST;
      st.strap_take <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign core_rst_n = !(st.hw_rst || ctl.busy);
  assign std_regs_rst = st.std_pulse;
  assign strap_latched = st.straps;
endmodule
`default_nettype wire

/* tb_prs_top.sv */
// Testbench for the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_prs_top;
  import prs_pkg::*;
  logic ref_clk, reset_n, rst_pin_n, wr, rd, core_rst_n, std_regs_rst;
  logic [2:0] strap_pins, strap_latched;
  prs_addr_t addr;
  prs_data_t wdata, got;
  logic [15:0] rdata;
  int errors = 0;
  int checked = 0;
  prs_top u_prs_top (.ref_clk, .reset_n, .rst_pin_n, .strap_pins, .addr, .wdata, .wr, .rd,
    .rdata, .core_rst_n, .std_regs_rst, .strap_latched);
  prs_host u_prs_host (.ref_clk, .rst_pin_n, .addr, .wdata, .wr, .rd, .rdata);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic cmp(input prs_data_t g, input prs_data_t e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input prs_addr_t a, input prs_data_t e);
    u_prs_host.read(a, got);
    cmp(got, e);
  endtask
  task automatic give_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  initial begin
    reset_n = 1'b0;
    strap_pins = 3'h5;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait (rst_pin_n === 1'b1);
    repeat (8) @(posedge ref_clk);
    rchk(12'h000, 16'h1140);
    rchk(12'h01F, 16'h0000);
    rchk(12'h05A, 16'h0000);
    $display("test power-up done");
    u_prs_host.write(12'h010, 16'hA5A5);
    u_prs_host.write(12'h000, 16'h8000);
    repeat (24) @(posedge ref_clk);
    rchk(12'h000, 16'h1140);
    rchk(12'h010, 16'hA5A5);
    $display("test standard reset done");
    strap_pins <= 3'h2;
    u_prs_host.write(12'h01F, 16'h8000);
    repeat (24) @(posedge ref_clk);
    rchk(12'h010, 16'h0000);
    rchk(12'h01F, 16'h0000);
    cmp(16'(strap_latched), 16'h0005);
    $display("test global reset done");
    u_prs_host.write(12'h010, 16'h5A5A);
    u_prs_host.write(12'h01F, 16'h4000);
    repeat (24) @(posedge ref_clk);
    rchk(12'h01F, 16'h0000);
    rchk(12'h010, 16'h5A5A);
    $display("test restart done");
    u_prs_host.pulse(6);
    repeat (8) @(posedge ref_clk);
    u_prs_host.pulse(20);
    repeat (8) @(posedge ref_clk);
    rchk(12'h010, 16'h5A5A);
    u_prs_host.pulse(32);
    repeat (8) @(posedge ref_clk);
    rchk(12'h010, 16'h0000);
    cmp(16'(strap_latched), 16'h0002);
    rchk(12'h06E, 16'h0002);
    $display("test pin reset done");
    for (int m = 2; m <= 3; m++) begin
      u_prs_host.write(12'h01D, 16'(m));
      u_prs_host.write(12'h003, 16'h1230 + 16'(m));
      rchk(12'hC03, 16'h1230 + 16'(m));
    end
    u_prs_host.write(12'h01D, 16'h0000);
    rchk(12'h000, 16'h1140);
    $display("test fiber map done");
    give_verdict();
  end
endmodule
`default_nettype wire
